// [sim/host_model.sv]
/*
  Host model: drives the serial control pins on a 160 ns link clock.
  Assumes the device clock is 4 ns and tasks start 1 ns after its edge.
*/
`timescale 1ns/1ns
module host_model (
  input wire logic sdio_dev_i,
  input wire logic sdio_oe_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_line_o,
  output logic io_reset_o,
  output logic io_update_o,
  output logic [2:0] profile_o
);
  logic host_d = 1'b0;
  logic rel = 1'b0;
  logic lsb = 1'b0;
  logic three = 1'b0;
  logic oe_seen = 1'b0;
  logic so_seen = 1'b0;
  logic pause_oe = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_reset_o = 1'b0;
    io_update_o = 1'b0;
    profile_o = 3'h0;
  end
  // Released line toggles so a stale value never reads as valid
  assign sdio_line_o = sdio_oe_i ? sdio_dev_i : host_d;
  always @(posedge sdio_oe_i) oe_seen <= 1'b1;
  always @(posedge sdo_oe_i) so_seen <= 1'b1;

  // Mode 1 pauses with select high at bit brk, mode 2 aborts there
  task automatic shift(input logic [63:0] v, input int n, input int brk, input int mode,
                       output logic [63:0] r);
    int k;
    r = '0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      if (i == brk && mode == 1) begin
        cs_n_o = 1'b1;
        repeat (2) begin
          #80 sclk_o = 1'b1;
          #80 sclk_o = 1'b0;
        end
        pause_oe = sdio_oe_i | sdo_oe_i;
        cs_n_o = 1'b0;
        #80;
      end
      if (i == brk && mode == 2) begin
        io_reset_o = 1'b1;
        #80 io_reset_o = 1'b0;
        #80;
        return;
      end
      host_d = rel ? ~host_d : v[k];
      #80 sclk_o = 1'b1;
      r[k] = three ? sdo_i : sdio_line_o;
      #80 sclk_o = 1'b0;
    end
  endtask

  task automatic cycle(input logic [7:0] ins, input logic [63:0] wd, input int brk, input int mode,
                       output logic [63:0] rd);
    logic [63:0] junk;
    int nb;
    nb = (ins[4:0] >= 5'h0e && ins[4:0] <= 5'h15) ? 8 : 4;
    oe_seen = 1'b0;
    so_seen = 1'b0;
    rel = 1'b0;
    cs_n_o = 1'b0;
    #80;
    shift({56'h0, ins}, 8, -1, 0, junk);
    rel = ins[7];
    shift(wd, nb * 8, brk, mode, rd);
    rel = 1'b0;
    cs_n_o = 1'b1;
    #80;
  endtask

  task automatic update();
    io_update_o = 1'b1;
    #32 io_update_o = 1'b0;
  endtask
endmodule // host_model

// [sim/serial_control_port_bench.sv]
/*
  Self-checking bench of the serial control port with the host model.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ns
`include "scp_regs.svh"
module serial_control_port_bench;
  logic clk;
  logic rst;
  logic sclk, cs_n, sdio, io_reset, io_update, sdio_o, sdio_oe, serial_out_pin, sdo_oe, upd_o, upd_oe, done;
  logic [2:0] profile;
  logic [63:0] rd, v, w, x;
  int error_cnt = 0;
  int samples_checked = 0;

  serial_control_port i_dut (.sys_clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n),
    .sdio_i(sdio), .io_reset_i(io_reset), .io_update_i(io_update), .profile_i(profile),
    .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .serial_out_pin_o(serial_out_pin), .serial_out_pin_oe_o(sdo_oe),
    .io_update_o(upd_o), .io_update_oe_o(upd_oe), .update_done_o(done));
  host_model i_host (.sdio_dev_i(sdio_o), .sdio_oe_i(sdio_oe), .sdo_i(serial_out_pin), .sdo_oe_i(sdo_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .sdio_line_o(sdio), .io_reset_o(io_reset),
    .io_update_o(io_update), .profile_o(profile));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Don't-care bits get random values
  function automatic logic [7:0] mk(input logic r, input logic [4:0] a);
    logic [31:0] t;
    t = $urandom;
    return {r, t[1:0], a};
  endfunction

  // Whole bytes before the abort point survive, the rest stay old
  function automatic logic [63:0] after_abort(input logic [63:0] old, input logic [63:0] nw, input int bits);
    logic [63:0] m;
    m = ~(64'hffff_ffff >> (8 * (bits / 8))) & 64'hffff_ffff;
    return (nw & m) | (old & ~m);
  endfunction

  task automatic xfer(input logic r, input logic [4:0] a, input logic [63:0] d, input int brk, input int mode);
    @(posedge clk) #1;
    i_host.cycle(mk(r, a), d, brk, mode, rd);
  endtask

  task automatic upd();
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk) #1;
    fork
      i_host.update();
      // Latch the one-cycle done pulse: the strobe task outlives it
      while (got !== 1'b1 && n < 12) begin
        @(posedge clk) #1;
        n++;
        got = done;
      end
    join
    chk({63'h0, got}, 64'h1);
  endtask

  // Roughly twice the expected run length
  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    void'($urandom(29));
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    xfer(1, 5'h01, 0, -1, 0);
    chk(rd, `SCP_RST_CTRL2);
    xfer(1, 5'h02, 0, -1, 0);
    chk(rd, `SCP_RST_CTRL3);
    $display("test reset values done");

    v = {32'h0, $urandom};
    xfer(0, 5'h03, v, -1, 0);
    xfer(1, 5'h03, 0, -1, 0);
    chk(rd, 64'h0);
    upd();
    xfer(1, 5'h03, 0, -1, 0);
    chk(rd, v);
    $display("test shadow commit done");

    w = {32'h0, $urandom};
    x = {32'h0, $urandom};
    xfer(0, 5'h04, w, 19, 2);
    xfer(0, 5'h05, x, -1, 0);
    upd();
    xfer(1, 5'h04, 0, -1, 0);
    chk(rd, after_abort(64'h0, w, 19));
    xfer(1, 5'h05, 0, -1, 0);
    chk(rd, x);
    xfer(1, 5'h03, 0, -1, 0);
    chk(rd, v);
    $display("test abort done");

    w = {32'h0, $urandom & 32'hff7f_ffff};
    xfer(0, 5'h01, w, 9, 1);
    chk({63'h0, i_host.pause_oe}, 64'h0);
    upd();
    xfer(1, 5'h01, 0, 20, 1);
    chk(rd, w);
    chk({63'h0, i_host.pause_oe}, 64'h0);
    chk({63'h0, i_host.so_seen}, 64'h0);
    chk({63'h0, i_host.oe_seen}, 64'h1);
    $display("test select pause done");

    x = {$urandom, $urandom};
    xfer(0, 5'h13, x, -1, 0);
    @(posedge clk) #1;
    i_host.profile_o = 3'h5;
    repeat (10) @(posedge clk);
    #1;
    xfer(1, 5'h13, 0, -1, 0);
    chk(rd, x);
    $display("test profile done");

    xfer(0, 5'h00, 64'h1, -1, 0);
    upd();
    i_host.lsb = 1'b1;
    v = {32'h0, $urandom};
    xfer(0, 5'h03, v, -1, 0);
    upd();
    xfer(1, 5'h03, 0, -1, 0);
    chk(rd, v);
    xfer(0, 5'h00, 64'h3, -1, 0);
    upd();
    i_host.three = 1'b1;
    xfer(1, 5'h03, 0, -1, 0);
    chk(rd, v);
    chk({63'h0, i_host.oe_seen}, 64'h0);
    chk({63'h0, i_host.so_seen}, 64'h1);
    $display("test bit order and pins done");

    xfer(0, 5'h01, 64'h0080_0000, -1, 0);
    upd();
    chk({63'h0, upd_oe}, 64'h1);
    for (int n = 0; n < 1100 && upd_o !== 1'b1; n++) begin
      @(posedge clk) #1;
    end
    chk({63'h0, upd_o}, 64'h1);
    $display("test internal update done");
    final_report();
  end
endmodule // serial_control_port_bench

// [verilog/bit_sync.sv]
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes each bit is independent; no multi-bit coherence is promised.
*/
`timescale 1ns/1ns
module bit_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule // bit_sync

// [verilog/reg_bank.sv]
/*
  Shadow buffer and active registers, 32 addresses of up to 64 bits.
  Assumes byte writes and commit pulses come from the same clock domain.
*/
`timescale 1ns/1ns
`include "scp_regs.svh"
module reg_bank
  import scp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input byte_wr_type wr_i,
  input wire logic commit_i,
  input wire logic [4:0] rd_addr_i,
  output logic [63:0] rd_data_o,
  output logic [63:0] ctrl1_o,
  output logic [63:0] ctrl2_o
);
  logic [63:0] shadow_q [0:31];
  logic [63:0] shadow_d [0:31];
  logic [63:0] active_q [0:31];
  logic [63:0] active_d [0:31];

  always_comb begin
    shadow_d = shadow_q;
    active_d = active_q;
    if (wr_i.en) begin
      shadow_d[wr_i.addr][{wr_i.idx, 3'h0} +: 8] = wr_i.data;
    end
    // Copy the post-write buffer so a byte landing with the strobe is kept
    if (commit_i) begin
      active_d = shadow_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 32; i++) begin
        shadow_q[i] <= reg_reset(5'(i));
        active_q[i] <= reg_reset(5'(i));
      end
    end else begin
      shadow_q <= shadow_d;
      active_q <= active_d;
    end
  end

  assign rd_data_o = active_q[rd_addr_i];
  assign ctrl1_o = active_q[`SCP_ADDR_CTRL1];
  assign ctrl2_o = active_q[`SCP_ADDR_CTRL2];
endmodule // reg_bank

// [verilog/scp_pkg.sv]
/*
  Types and shared decode for the serial control port.
  Assumes the constants header is on the include path.
*/
package scp_pkg;
  `include "scp_regs.svh"

  typedef enum logic {ST_INSTR, ST_DATA} port_state_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdio;
    logic io_reset;
    logic io_update;
    logic [2:0] profile;
  } pin_in_type;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [2:0] idx;
    logic [7:0] data;
  } byte_wr_type;

  function automatic logic [3:0] reg_bytes(input logic [4:0] a);
    if (a >= `SCP_ADDR_PROF_FIRST && a <= `SCP_ADDR_PROF_LAST) begin
      return `SCP_BYTES_PROFILE;
    end
    return `SCP_BYTES_NORMAL;
  endfunction

  function automatic logic [63:0] reg_reset(input logic [4:0] a);
    case (a)
      `SCP_ADDR_CTRL1: return `SCP_RST_CTRL1;
      `SCP_ADDR_CTRL2: return `SCP_RST_CTRL2;
      `SCP_ADDR_CTRL3: return `SCP_RST_CTRL3;
      default: return `SCP_RST_OTHER;
    endcase
  endfunction
endpackage

// [verilog/scp_regs.svh]
/*
  Constants of the serial control port: register addresses, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_ADDR_CTRL1 5'h00
`define SCP_ADDR_CTRL2 5'h01
`define SCP_ADDR_CTRL3 5'h02
`define SCP_ADDR_PROF_FIRST 5'h0e
`define SCP_ADDR_PROF_LAST 5'h15

`define SCP_BIT_RW 7
`define SCP_BIT_LSB_FIRST 0
`define SCP_BIT_INPUT_ONLY 1
`define SCP_BIT_UPD_INTERNAL 23

`define SCP_RST_CTRL1 64'h0000_0000_0000_0000
`define SCP_RST_CTRL2 64'h0000_0000_0040_0820
`define SCP_RST_CTRL3 64'h0000_0000_1f3f_4000
`define SCP_RST_OTHER 64'h0000_0000_0000_0000

`define SCP_BYTES_NORMAL 4'h4
`define SCP_BYTES_PROFILE 4'h8

// Sync clock is the system clock divided by this count
`define SCP_SYNC_DIV 16'h0004
`define SCP_UPD_PERIOD 16'h0400
`define SCP_UPD_WIDTH 16'h0008

`endif

// [verilog/serial_control_port.sv]
/*
  Serial control port of a synthesizer: instruction byte, register-length
  data phase, shadow buffer committed by an update strobe or profile change.
  Assumes every pin is asynchronous to sys_clk_i and the serial clock is
  well below a quarter of the system clock, so both edges are seen.
*/
//
// Contract
// - Cycle is instruction byte then data phase
// - Instruction bit seven high reads, low writes
// - Instruction bits six and five ignored
// - Instruction low five bits give address
// - Data bytes equal addressed register width
// - Write bits captured on serial rising edge
// - Abort ends cycle, resets byte pointer
// - Abort keeps whole bytes, drops partial byte
// - After cycle, next eight edges are instruction
// - Writes wait in shadow until update strobe
// - Profile pin change also commits shadow
// - Reads return active registers, driven on fall
// - Select high tristates both data outputs
// - Select high pauses cycle, resumes later
// - Control bit one picks input-only data pin
// - Bidirectional mode keeps separate output tristated
// - Abort resyncs port, registers unchanged
// - Update taken on rising edge, long pulse
// - Internal bit makes update pin output
// - Control bit zero selects LSB-first order
`timescale 1ns/1ns
`include "scp_regs.svh"
module serial_control_port
  import scp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  input wire logic io_reset_i,
  input wire logic io_update_i,
  input wire logic [2:0] profile_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  output logic io_update_o,
  output logic io_update_oe_o,
  output logic update_done_o
);
  pin_in_type pin_raw;
  pin_in_type pin_s;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic rise;
  logic fall;

  port_state_type state_q;
  port_state_type state_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [4:0] addr_q;
  logic [4:0] addr_d;
  logic rd_q;
  logic rd_d;
  logic [7:0] byte_now;
  logic [3:0] nbytes;
  logic [6:0] last;
  logic [5:0] bit_idx;
  logic [2:0] byte_idx;
  byte_wr_type wr;

  logic out_q;
  logic out_d;
  logic sdio_oe_q;
  logic sdio_oe_d;
  logic sdo_oe_q;
  logic sdo_oe_d;
  logic drive;

  logic [63:0] rd_data;
  logic [63:0] ctrl1;
  logic [63:0] ctrl2;
  logic [4:0] rd_addr;
  logic lsb_first;
  logic input_only;
  logic upd_internal;

  logic upd_prev_q;
  logic upd_prev_d;
  logic [2:0] prof_prev_q;
  logic [2:0] prof_prev_d;
  logic [15:0] gen_cnt_q;
  logic [15:0] gen_cnt_d;
  logic upd_out_q;
  logic upd_out_d;
  logic upd_oe_q;
  logic upd_oe_d;
  logic upd_src;
  logic upd_edge;
  logic prof_chg;
  logic commit;
  logic done_q;
  logic done_d;

  assign pin_raw = '{sclk: sclk_i, cs_n: cs_n_i, sdio: sdio_i, io_reset: io_reset_i,
                     io_update: io_update_i, profile: profile_i};

  // Pins cross into the system clock before anything reads them
  bit_sync #(.WIDTH(8)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  reg_bank u_bank (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(wr),
    .commit_i(commit),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data),
    .ctrl1_o(ctrl1),
    .ctrl2_o(ctrl2)
  );

  assign lsb_first = ctrl1[`SCP_BIT_LSB_FIRST];
  assign input_only = ctrl1[`SCP_BIT_INPUT_ONLY];
  assign upd_internal = ctrl2[`SCP_BIT_UPD_INTERNAL];

  // Edges count only while selected and not aborted: a deselect freezes the cycle
  assign rise = pin_s.sclk & ~sclk_prev_q & ~pin_s.cs_n & ~pin_s.io_reset;
  assign fall = ~pin_s.sclk & sclk_prev_q & ~pin_s.cs_n & ~pin_s.io_reset;

  always_comb begin
    byte_now = lsb_first ? {pin_s.sdio, shift_q[7:1]} : {shift_q[6:0], pin_s.sdio};
    nbytes = reg_bytes(addr_q);
    last = 7'({nbytes, 3'h0} - 7'h01);
    bit_idx = lsb_first ? cnt_q[5:0] : 6'(last[5:0] - cnt_q[5:0]);
    byte_idx = lsb_first ? cnt_q[5:3] : 3'(nbytes - 4'h1 - {1'b0, cnt_q[5:3]});
    // Profile registers read back the one picked by the profile pins
    if (addr_q >= `SCP_ADDR_PROF_FIRST && addr_q <= `SCP_ADDR_PROF_LAST) begin
      rd_addr = 5'(`SCP_ADDR_PROF_FIRST + {2'h0, pin_s.profile});
    end else begin
      rd_addr = addr_q;
    end
  end

  always_comb begin
    sclk_prev_d = pin_s.sclk;
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    rd_d = rd_q;
    wr = '0;
    if (pin_s.io_reset) begin
      // Pointer and partial byte drop; shadow and active are untouched
      state_d = ST_INSTR;
      cnt_d = '0;
      shift_d = '0;
      rd_d = 1'b0;
    end else if (rise) begin
      shift_d = byte_now;
      cnt_d = 7'(cnt_q + 7'h01);
      case (state_q)
        ST_INSTR: begin
          if (cnt_q == 7'h07) begin
            rd_d = byte_now[`SCP_BIT_RW];
            addr_d = byte_now[4:0];
            state_d = ST_DATA;
            cnt_d = '0;
          end
        end
        ST_DATA: begin
          if (!rd_q && cnt_q[2:0] == 3'h7) begin
            // Each whole byte lands in the shadow at once, so an abort keeps it
            wr.en = 1'b1;
            wr.addr = addr_q;
            wr.idx = byte_idx;
            wr.data = byte_now;
          end
          if (cnt_q == last) begin
            state_d = ST_INSTR;
            cnt_d = '0;
          end
        end
        default: begin
          state_d = ST_INSTR;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      state_q <= ST_INSTR;
      cnt_q <= '0;
      shift_q <= '0;
      addr_q <= '0;
      rd_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
    end
  end

  always_comb begin
    drive = ~pin_s.cs_n & ~pin_s.io_reset & (state_q == ST_DATA) & rd_q;
    sdio_oe_d = drive & ~input_only;
    sdo_oe_d = drive & input_only;
    out_d = out_q;
    if (fall && state_q == ST_DATA && rd_q) begin
      out_d = rd_data[bit_idx];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      sdio_oe_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      sdio_oe_q <= sdio_oe_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  always_comb begin
    upd_oe_d = upd_internal;
    gen_cnt_d = 16'(gen_cnt_q + 16'h0001);
    if (!upd_internal || gen_cnt_q == 16'(`SCP_UPD_PERIOD - 16'h0001)) begin
      gen_cnt_d = '0;
    end
    // Internal pulse spans two sync clock periods
    upd_out_d = upd_internal && gen_cnt_q < `SCP_UPD_WIDTH;
    upd_src = upd_internal ? upd_out_q : pin_s.io_update;
    upd_prev_d = upd_src;
    upd_edge = upd_src & ~upd_prev_q;
    prof_prev_d = pin_s.profile;
    prof_chg = pin_s.profile != prof_prev_q;
    commit = upd_edge | prof_chg;
    done_d = commit;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gen_cnt_q <= '0;
      upd_out_q <= 1'b0;
      upd_oe_q <= 1'b0;
      upd_prev_q <= 1'b0;
      prof_prev_q <= '0;
      done_q <= 1'b0;
    end else begin
      gen_cnt_q <= gen_cnt_d;
      upd_out_q <= upd_out_d;
      upd_oe_q <= upd_oe_d;
      upd_prev_q <= upd_prev_d;
      prof_prev_q <= prof_prev_d;
      done_q <= done_d;
    end
  end

  assign sdio_o = out_q;
  assign sdio_oe_o = sdio_oe_q;
  assign serial_out_pin_o = out_q;
  assign serial_out_pin_oe_o = sdo_oe_q;
  assign io_update_o = upd_out_q;
  assign io_update_oe_o = upd_oe_q;
  assign update_done_o = done_q;

  a_cs_tristate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_s.cs_n |=> !sdio_oe_q && !serial_out_pin_oe_o)
    else $error("data outputs driven while deselected");

  a_bidir_no_sdo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !input_only |=> !sdo_oe_q)
    else $error("separate output driven in bidirectional mode");

  a_abort_resync: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_s.io_reset |=> state_q == ST_INSTR && cnt_q == 7'h00 && !rd_q)
    else $error("abort did not return port to instruction phase");

  a_instr_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rise && state_q == ST_INSTR && cnt_q == 7'h07
    |=> state_q == ST_DATA && addr_q == $past(byte_now[4:0]) && rd_q == $past(byte_now[7]))
    else $error("instruction byte decoded wrongly");

  a_write_on_rise: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr.en |-> rise && !rd_q && state_q == ST_DATA)
    else $error("shadow written outside a rising serial edge");

  a_read_on_fall: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_q != $past(out_q) |-> $past(fall) && $past(rd_q))
    else $error("read data changed outside a falling serial edge");

  a_profile_commit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_s.profile != $past(pin_s.profile) |=> update_done_o)
    else $error("profile change did not commit the buffer");

  a_select_pause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_s.cs_n && !pin_s.io_reset |=> $stable(cnt_q) && $stable(state_q) && $stable(shift_q))
    else $error("cycle advanced while deselected");

  a_cycle_end: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rise && state_q == ST_DATA && cnt_q == last |=> state_q == ST_INSTR && cnt_q == 7'h00)
    else $error("data phase length wrong");

  c_read_done: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rise && rd_q && state_q == ST_DATA && cnt_q == last);
  c_write_byte: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr.en);
  c_abort_mid: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    pin_s.io_reset && state_q == ST_DATA);
  c_commit_pin: cover property (@(posedge sys_clk_i) disable iff (rst_i) upd_edge && !upd_internal);
endmodule // serial_control_port
